/* File: include/cdim_pkg.sv */
// Constants shared by the channelizer data input mapper.
// Assumes an APB register port with 32-bit data and an 8-bit byte address.
package cdim_pkg;

  // Widths of the data path
  localparam int BUS_W     = 32;             // Data pins
  localparam int DDR_W     = 16;             // Pairs used on both edges
  localparam int SET_W     = 128;            // Normalised channel set
  localparam int NIB_N     = 32;             // Nibble slots in the set buffer
  localparam int CHAN_N    = 4;              // Channels per set
  localparam int IDX_W     = 5;              // Load cycle index width
  localparam int ADDR_W    = 8;              // APB address width

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STAT_OFF   = 8'h04;
  localparam logic [7:0] SETCNT_OFF = 8'h08;
  localparam logic [7:0] CHAN0_OFF  = 8'h10;
  localparam logic [7:0] CHAN1_OFF  = 8'h14;
  localparam logic [7:0] CHAN2_OFF  = 8'h18;
  localparam logic [7:0] CHAN3_OFF  = 8'h1C;

  // Control register fields
  localparam int CTRL_W        = 7;
  localparam int CTRL_EN_BIT   = 0;          // Capture enable
  localparam int CTRL_BW_LSB   = 1;          // Bus width select, two bits
  localparam int CTRL_LVDS_BIT = 3;          // 1 = LVDS signalling
  localparam int CTRL_S16_BIT  = 4;          // 1 = 16-bit samples
  localparam int CTRL_CPLX_BIT = 5;          // 1 = complex samples
  localparam int CTRL_LSBF_BIT = 6;          // 1 = low part of a sample first
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Status register fields
  localparam int STAT_CFGERR_BIT = 0;        // Unsupported combination
  localparam int STAT_OVR_BIT    = 1;        // Set lost while crossing busy

  // Bus width select codes
  typedef enum logic [1:0] {
    CDIM_BW4  = 2'b00,
    CDIM_BW8  = 2'b01,
    CDIM_BW16 = 2'b10,
    CDIM_BW32 = 2'b11
  } cdim_bw_t;

endpackage

/* File: logic/cdim_sync.sv */
// Two-flop level synchroniser, one bit or a quasi-static bus.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
module cdim_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

/* File: logic/cdim_input_mapper.sv */
// Channelizer data input mapper: captures the parallel sample bus on the
// data sample clock and assembles complete four-channel sets.
// Assumes an APB master on sys_clk and a source clocked by data_sample_clock.
//
// Operation
// [R1] CMOS words are taken once per clock, on the rising edge.
// [R2] LVDS at 4, 8 or 16 bits takes one word per clock.
// [R3] LVDS at 32 bits takes 16 pairs on both edges per clock.
// [R4] Bus width select picks low 4, 8, 16 or all 32 CMOS pins.
// [R5] LVDS maps codes to 4, 8, 16 pairs; code 11 reuses 16 on both edges.
// [R6] Only 8-bit real/complex, or 16-bit complex on 8+ bit buses, are supported.
// [R7] Narrow buses accumulate words until every channel sample is loaded.
// [R8] 4-bit bus, 8-bit real: two clocks per channel, eight per set.
// [R9] 4-bit bus, 8-bit complex: I then Q, two clocks each, sixteen per set.
// [R10] 8-bit bus, 8-bit real: one channel per clock, four per set.
// [R11] 8-bit bus, 8-bit complex: I byte then Q byte, eight per set.
// [R12] First nibble of a split sample is the upper one unless configured.
`timescale 1ns/1ps
module cdim_input_mapper (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         data_sample_clock,
  input  wire logic [31:0]  dataPins,
  output logic              setValid,
  output logic      [127:0] setData
);

  // ---------------- System domain signals ----------------
  logic [cdim_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0]                 setCount_r;
  logic                        seen_r;
  logic                        reqSys;
  logic                        ovrSys;
  logic                        cfgErrSys;
  logic                        setup;
  logic                        access;
  logic [31:0]                 rdNxt;
  logic                        badNxt;

  // ---------------- Link domain signals ----------------
  logic                        linkRstN;
  logic [cdim_pkg::CTRL_W-1:0] cfgLink;
  logic                        linkEn;
  cdim_pkg::cdim_bw_t          linkBw;
  logic                        linkLvds;
  logic                        linkS16;
  logic                        linkCplx;
  logic                        linkLsbF;
  logic                        legal;
  logic                        active;
  logic [31:0]                 capR_r;
  logic [15:0]                 capF_r;
  logic [31:0]                 word;
  logic [2:0]                  wLog;
  logic [2:0]                  sLog;
  logic [2:0]                  cycLog;
  logic [2:0]                  pLog;
  logic [4:0]                  pMask;
  logic [4:0]                  piece;
  logic [4:0]                  slotIdx;
  logic [6:0]                  offN;
  logic [6:0]                  laneN;
  logic [4:0]                  lastIdx;
  logic [4:0]                  loadIdx_r;
  logic                        setDone;
  logic [127:0]                buf_r;
  logic [127:0]                bufNxt;
  logic [127:0]                setNorm;
  logic [127:0]                hold_r;
  logic                        reqTog_r;
  logic                        ackLink;
  logic                        busy;
  logic                        overrun_r;

  // Configuration field split, system side
  assign cfgErrSys = ctrl_r[cdim_pkg::CTRL_S16_BIT]
                     && (!ctrl_r[cdim_pkg::CTRL_CPLX_BIT]
                         || ctrl_r[cdim_pkg::CTRL_BW_LSB +: 2] == cdim_pkg::CDIM_BW4); // R6

  // APB phases; zero wait states, read data latched in setup
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = access;

  // Read mux and address check
  always_comb begin
    rdNxt  = 32'h0000_0000;
    badNxt = 1'b0;
    unique case (paddr)
      cdim_pkg::CTRL_OFF:   rdNxt = {25'h0, ctrl_r};
      cdim_pkg::STAT_OFF:   rdNxt = {30'h0, ovrSys, cfgErrSys};
      cdim_pkg::SETCNT_OFF: rdNxt = setCount_r;
      cdim_pkg::CHAN0_OFF:  rdNxt = setData[31:0];
      cdim_pkg::CHAN1_OFF:  rdNxt = setData[63:32];
      cdim_pkg::CHAN2_OFF:  rdNxt = setData[95:64];
      cdim_pkg::CHAN3_OFF:  rdNxt = setData[127:96];
      default:              badNxt = 1'b1;
    endcase
  end

  // Read data and error answer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdNxt;
      pslverr <= badNxt;
    end
  end

  // Control register write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= cdim_pkg::CTRL_RESET;
    end else if (access && pwrite && paddr == cdim_pkg::CTRL_OFF) begin
      ctrl_r <= pwdata[cdim_pkg::CTRL_W-1:0];
    end
  end

  // Set hand-off into the system domain
  cdim_sync #(.WIDTH(1)) uReqSync (
    .clk  (sys_clk),
    .rstN (arst_n),
    .din  (reqTog_r),
    .dout (reqSys)
  );

  cdim_sync #(.WIDTH(1)) uOvrSync (
    .clk  (sys_clk),
    .rstN (arst_n),
    .din  (overrun_r),
    .dout (ovrSys)
  );

  // Copy a new set, pulse valid, count sets
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_r     <= 1'b0;
      setValid   <= 1'b0;
      setData    <= '0;
      setCount_r <= 32'h0000_0000;
    end else begin
      setValid <= 1'b0;
      if (reqSys != seen_r) begin
        seen_r     <= reqSys;             // Acts as the acknowledge toggle
        setValid   <= 1'b1;
        setData    <= hold_r;             // Stable while request is open
        setCount_r <= setCount_r + 32'h0000_0001;
      end
    end
  end

  // ---------------- Link domain ----------------

  // Reset released in step with the link clock
  cdim_sync #(.WIDTH(1)) uRstSync (
    .clk  (data_sample_clock),
    .rstN (arst_n),
    .din  (1'b1),
    .dout (linkRstN)
  );

  // Quasi-static configuration into the link domain
  cdim_sync #(.WIDTH(cdim_pkg::CTRL_W)) uCfgSync (
    .clk  (data_sample_clock),
    .rstN (linkRstN),
    .din  (ctrl_r),
    .dout (cfgLink)
  );

  cdim_sync #(.WIDTH(1)) uAckSync (
    .clk  (data_sample_clock),
    .rstN (linkRstN),
    .din  (seen_r),
    .dout (ackLink)
  );

  // Configuration fields, link side
  assign linkEn   = cfgLink[cdim_pkg::CTRL_EN_BIT];
  assign linkBw   = cdim_pkg::cdim_bw_t'(cfgLink[cdim_pkg::CTRL_BW_LSB +: 2]);
  assign linkLvds = cfgLink[cdim_pkg::CTRL_LVDS_BIT];
  assign linkS16  = cfgLink[cdim_pkg::CTRL_S16_BIT];
  assign linkCplx = cfgLink[cdim_pkg::CTRL_CPLX_BIT];
  assign linkLsbF = cfgLink[cdim_pkg::CTRL_LSBF_BIT];
  assign legal    = !(linkS16 && (!linkCplx || linkBw == cdim_pkg::CDIM_BW4)); // R6
  assign active   = linkEn && legal;     // R6

  // Rising edge capture of the whole bus
  always_ff @(posedge data_sample_clock or negedge linkRstN) begin
    if (!linkRstN) begin
      capR_r <= 32'h0000_0000;
    end else begin
      capR_r <= dataPins;                // R1 R2
    end
  end

  // Falling edge capture of the shared pairs
  always_ff @(negedge data_sample_clock or negedge linkRstN) begin
    if (!linkRstN) begin
      capF_r <= 16'h0000;
    end else begin
      capF_r <= dataPins[cdim_pkg::DDR_W-1:0]; // R3
    end
  end

  // Active lanes by bus width and signalling
  always_comb begin
    unique case (linkBw)
      cdim_pkg::CDIM_BW4:  word = {28'h0, capR_r[3:0]};   // R4 R5
      cdim_pkg::CDIM_BW8:  word = {24'h0, capR_r[7:0]};   // R4 R5
      cdim_pkg::CDIM_BW16: word = {16'h0, capR_r[15:0]};  // R4 R5
      cdim_pkg::CDIM_BW32: word = linkLvds ? {capF_r, capR_r[15:0]} : capR_r; // R3 R5
    endcase
  end

  // Set geometry in powers of two
  assign wLog    = {1'b0, linkBw} + 3'd2;
  assign sLog    = linkS16 ? 3'd4 : 3'd3;
  assign cycLog  = sLog + {2'b00, linkCplx} + 3'd2 - wLog;          // R8 R9 R10 R11
  assign lastIdx = 5'((6'd1 << cycLog) - 6'd1);                     // R7
  assign pLog    = (sLog > wLog) ? sLog - wLog : 3'd0;
  assign pMask   = 5'((6'd1 << pLog) - 6'd1);
  assign piece   = loadIdx_r & pMask;

  // Slot of the current word; upper part first by default
  assign slotIdx = linkLsbF ? loadIdx_r
                            : loadIdx_r - piece + (pMask - piece);  // R12
  assign offN    = 7'({2'b00, slotIdx} << (wLog - 3'd2));
  assign laneN   = 7'(7'd1 << (wLog - 3'd2));

  // Each nibble slot takes its lane of the word when the word covers it
  genvar n;
  generate
    for (n = 0; n < cdim_pkg::NIB_N; n++) begin : gNib
      wire [6:0] rel = 7'(n) - offN;
      wire       hit = (7'(n) >= offN) && (rel < laneN);
      assign bufNxt[n*4 +: 4] = hit ? word[{rel[2:0], 2'b00} +: 4] : buf_r[n*4 +: 4]; // R7
    end
  endgenerate

  // Spread assembled terms into one I/Q word per channel
  genvar k;
  generate
    for (k = 0; k < cdim_pkg::CHAN_N; k++) begin : gChan
      wire [15:0] iTerm = linkS16  ? bufNxt[32*k +: 16]
                        : linkCplx ? {8'h00, bufNxt[16*k +: 8]}
                        : {8'h00, bufNxt[8*k +: 8]};
      wire [15:0] qTerm = !linkCplx ? 16'h0000
                        : linkS16   ? bufNxt[32*k+16 +: 16]
                        : {8'h00, bufNxt[16*k+8 +: 8]};
      assign setNorm[32*k +: 32] = {qTerm, iTerm};
    end
  endgenerate

  assign setDone = active && loadIdx_r == lastIdx;
  assign busy    = reqTog_r != ackLink;

  // Load cycle index and accumulation buffer
  always_ff @(posedge data_sample_clock or negedge linkRstN) begin
    if (!linkRstN) begin
      loadIdx_r <= 5'd0;
      buf_r     <= '0;
    end else if (!active) begin
      loadIdx_r <= 5'd0;
      buf_r     <= '0;
    end else begin
      loadIdx_r <= setDone ? 5'd0 : loadIdx_r + 5'd1; // R7
      buf_r     <= bufNxt;
    end
  end

  // Hand a complete set across; flag a set lost while busy
  always_ff @(posedge data_sample_clock or negedge linkRstN) begin
    if (!linkRstN) begin
      hold_r    <= '0;
      reqTog_r  <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (setDone && !busy) begin
        hold_r   <= setNorm;             // R7
        reqTog_r <= ~reqTog_r;
      end
      if (setDone && busy) begin
        overrun_r <= 1'b1;               // Set wins over clear
      end else if (!linkEn) begin
        overrun_r <= 1'b0;
      end
    end
  end

endmodule

/* File: verif/cdim_input_mapper_sva.sv */
// Checker on the mapper's top-level ports.
// Assumes binding into cdim_input_mapper; shadows CTRL from APB writes.
`timescale 1ns/1ps
module cdim_input_mapper_sva (
  input wire logic         sys_clk,
  input wire logic         arst_n,
  input wire logic [7:0]   paddr,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         setValid,
  input wire logic [127:0] setData
);
  logic [6:0] ctrl_r;
  logic [6:0] modeRun_r;
  logic [4:0] offCnt_r;
  logic       blk;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Control shadow
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) ctrl_r <= 7'h00;
    else if (psel && penable && pwrite && paddr == 8'h00) ctrl_r <= pwdata[6:0];
  end
  // Mode of the last enable; sets still in flight after a disable keep it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) modeRun_r <= 7'h00;
    else if (psel && penable && pwrite && paddr == 8'h00 && pwdata[0]) modeRun_r <= pwdata[6:0];
  end
  // Disabled, or 16-bit real, or 16-bit on the 4-bit bus
  assign blk = !ctrl_r[0] || (ctrl_r[4] && (!ctrl_r[5] || ctrl_r[2:1] == 2'b00));
  // Blocked cycles, saturating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) offCnt_r <= 5'h00;
    else if (!blk) offCnt_r <= 5'h00;
    else if (offCnt_r != 5'h1F) offCnt_r <= offCnt_r + 5'h01;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_ready; s_setup ##1 s_access |-> pready; endproperty
  property p_err; s_setup |=> pslverr ==
    !($past(paddr) inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C}); endproperty
  property p_hold; s_setup ##1 s_access |=> $stable(prdata); endproperty
  property p_pulse; setValid |=> !setValid; endproperty
  property p_quiet; $changed(setData) |-> setValid; endproperty
  property p_byte; setValid && !modeRun_r[4] |->
    (setData & {4{32'hFF00FF00}}) == 128'h0; endproperty
  property p_real; setValid && !modeRun_r[5] |-> (setData & {4{32'hFFFF0000}}) == 128'h0;
  endproperty
  property p_off; offCnt_r == 5'h1F && !ctrl_r[0] |-> !setValid; endproperty
  property p_cfg; offCnt_r == 5'h1F && ctrl_r[0] |-> !setValid; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_pulse: assert property (p_pulse) else $error("set valid too long");
  a_quiet: assert property (p_quiet) else $error("set changed alone");
  a_byte: assert property (p_byte) else $error("upper byte set");
  a_real: assert property (p_real) else $error("real set has Q");
  a_off: assert property (p_off) else $error("set while disabled");
  a_cfg: assert property (p_cfg) else $error("set on bad config");
endmodule
bind cdim_input_mapper cdim_input_mapper_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .setValid(setValid),
  .setData(setData));

/* File: verif/cdim_src_model.sv */
// Sample source model driving the data pins on the link clock.
// Assumes the bench hands it a fresh word every link period.
`timescale 1ns/1ps
module cdim_src_model (
  input wire logic        linkClk,
  input wire logic        ddr,
  input wire logic [31:0] nextWord,
  output logic     [31:0] dataPins
);
  logic [31:0] word_r;
  initial dataPins = 32'h0;
  // Word settles before rising edge; upper half follows for falling edge
  always @(linkClk) begin
    if (!linkClk) begin
      word_r <= nextWord;
      dataPins <= nextWord;
    end else if (ddr) dataPins[15:0] <= word_r[31:16];
  end
endmodule

/* File: verif/tb_top.sv */
// Testbench: APB setup of supported modes but 8-bit real on 32 bits (32-bit bus: LVDS for 8-bit, CMOS for 16-bit), random sample stream.
// Assumes the mapper, its bound checker and the source model.
`timescale 1ns/1ps
module tb_top;
  logic         sys_clk, linkClk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic         setValid, ddr, lvds;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, dataPins, nextWord, rd, seed, base;
  logic [127:0] setData, lastExp;
  logic [31:0]  wq[$];
  logic [6:0]   cfg = 7'h00;
  logic [4:0]   m;
  int           n_fail = 0, n_compared = 0, nxt, nw, step, sets = 0, k;
  bit           aligned;
  initial begin sys_clk = 0; forever #20 sys_clk = ~sys_clk; end
  initial begin linkClk = 0; #13; forever #40 linkClk = ~linkClk; end
  cdim_input_mapper u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_sample_clock(linkClk), .dataPins(dataPins),
    .setValid(setValid), .setData(setData));
  cdim_src_model u_src (.linkClk(linkClk), .ddr(ddr), .nextWord(nextWord),
    .dataPins(dataPins));
  assign ddr = cfg[3] && cfg[2:1] == 2'b11;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected set from captured words starting at s
  function automatic logic [127:0] exp_set(input int s);
    logic [127:0] e;
    logic [15:0]  v;
    int           w, b, t, p;
    e = '0;
    w = cfg[2:1] == 2'b11 ? 32 : 4 << cfg[2:1];
    b = cfg[4] ? 16 : 8;
    for (t = 0; t < (cfg[5] ? 8 : 4); t++) begin
      v = '0;
      if (w >= b) v = 16'(wq[s + t*b/w] >> (t*b%w)) & (b == 16 ? 16'hFFFF : 16'h00FF);
      else for (p = 0; p < b/w; p++)
        v = v | (16'(wq[s + t*b/w + p] & ((32'h1 << w) - 1)) << (w*(cfg[6] ? p : b/w-1-p)));
      e[32*(cfg[5] ? t/2 : t) + 16*(cfg[5] ? t%2 : 0) +: 16] = v;
    end
    return e;
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Random words to the source; pin monitor builds the captured stream
  always @(posedge linkClk) begin
    seed = xs(seed);
    nextWord <= seed;
    wq.push_back(dataPins);
  end
  // Falling edge half fills the upper part of the word just pushed
  always @(negedge linkClk) begin
    if (ddr && wq.size() > 0) begin
      wq[wq.size()-1] = {dataPins[15:0], wq[wq.size()-1][15:0]};
    end
  end
  // Locks on the first set, then checks every following one
  always @(posedge sys_clk) if (setValid === 1'b1) begin
    sets++;
    if (!aligned) begin
      for (int s = 0; s + nw <= wq.size() && !aligned; s++)
        if (exp_set(s) === setData) begin
          aligned = 1;
          nxt = s + step;
          lastExp = exp_set(s);
        end
    end else begin
      lastExp = exp_set(nxt);
      chk(setData, lastExp);
      nxt += step;
    end
  end
  initial begin #3000000; n_fail++; final_report; end
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; seed = 32'hD285; nextWord = 32'h0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1;
    repeat (4) @(posedge sys_clk);
    apb(0, 8'h00, 0); chk(rd, 0);
    apb(1, 8'h04, 32'hFFFFFFFF); apb(0, 8'h04, 0); chk(rd, 0);
    apb(0, 8'h0C, 0); chk({err, rd}, 33'h100000000);
    apb(0, 8'h02, 0); chk(err, 1);
    $display("register checks done");
    for (int i = 0; i < 2; i++) begin
      apb(1, 8'h00, i ? 32'h31 : 32'h13); repeat (50) @(posedge sys_clk);
      apb(0, 8'h04, 0); chk(rd[0], 1);
      chk(sets, 0);
      apb(1, 8'h00, 0); repeat (40) @(posedge sys_clk);
    end
    $display("unsupported config checks done");
    for (int i = 0; i < 32; i++) begin
      m = i[4:0];
      if ((m[2] && (!m[3] || m[1:0] == 2'b00)) || m[3:0] == 4'b0011) continue;
      lvds = m[1:0] == 2'b11 ? !m[2] : seed[1];
      cfg = {m[4], m[3], m[2], lvds, m[1:0], 1'b1};
      nw = (m[3] ? 8 : 4) * (m[2] ? 16 : 8) / (m[1:0] == 2'b11 ? 32 : 4 << m[1:0]);
      // Handoff outlasts two link periods: two-cycle sets lose every other one
      step = nw < 4 ? 4 : nw;
      apb(0, 8'h08, 0);
      base = rd;
      wq.delete(); aligned = 0; sets = 0;
      apb(1, 8'h00, {25'h0, cfg});
      for (k = 0; k < 3000 && sets < 6; k++) @(posedge sys_clk);
      apb(0, 8'h04, 0);
      chk(rd[1], nw < 4);
      apb(1, 8'h00, 0); repeat (40) @(posedge sys_clk);
      chk(aligned, 1);
      chk(sets > 5, 1);
      apb(0, 8'h08, 0);
      chk(rd - base, sets);
      for (k = 0; k < 4; k++) begin
        apb(0, 8'h10 + 8'(4*k), 0);
        chk(rd, lastExp[32*k +: 32]);
      end
      $display("mode %h done, %0d sets", cfg, sets);
    end
    final_report;
  end
endmodule
